// >>> common/fault_consts.svh
// Behaviour
// - following error: code 09, coast, closed, bit19
// - encoder init error: code 10, inhibit, open
// - overspeed: code 11, stop, release, bit23
// - phase offset imbalance: code 12, inhibit, bit24
// - motor below -10C: code 13, inhibit, bit12
// - bad bus lengths: code 14, inhibit, closed
// - control message missing 3 cycles: code 15
// - transistor overcurrent: code 16, coast, release, bit16
// - enable sequence fault: code 17, stop, bit26
// - ready lost while enabled: code 18, bit22
// - motor overtemperature: code 19, stop, bit2
// - continuous overload: code 20, stop, bit20
// - drive overtemperature: code 25, stop, bit30
// - transistor enable fault: code 26, release, bit31
// - encoder battery low: code 27, inhibit, bit27
// - fan or sensor fault: code 28, status bit19
// - forbidden state change enabled: code 29, bit25
// - parameter checksum bad: code 30, inhibit, bit17
// - sync faulty 3 cycles: code 31, bit15
// - protected storage fault: code 32, inhibit, bit21
// - no fault: code 00, control, closed
// - faults latch until cleared; ready held off
// - clear on rising request edge, enable off
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH
`define N_FAULT 20
`define MISS_LIMIT 3
`define CNT_W 2
`define CLEAR_ACK_BIT 4
`define REG_CAUSE 32'h0000_0000
`define REG_ERRW 32'h0000_0004
`define REG_EXTW 32'h0000_0008
`define REG_STAT 32'h0000_000c
`define REG_CTRL 32'h0000_0010
`define CTRL_CLEAR_BIT 9
`define CTRL_ENABLE_BIT 0
`define WD_IDX 6
`define SYNC_IDX 18
`define CODE_NONE 8'h00
`define STOP_TIME_US 1000
`define STOP_CYCLES ((`STOP_TIME_US * 100) - 1)
`define DEFECT_DATA 32'hdead_beef
`endif

// >>> common/fault_pkg.sv
package fault_pkg;
   typedef enum logic [1:0] {
      REACT_CONTROL = 2'h0,
      REACT_COAST   = 2'h1,
      REACT_STOP    = 2'h2,
      REACT_INHIBIT = 2'h3
   } react_t;
   typedef struct packed {
      logic [7:0]  code;
      react_t      react;
      logic        contact_open;
      logic [31:0] err_mask;
      logic [31:0] ext_mask;
   } fault_entry_t;
   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_STOP = 3'b010,
      ST_OFF  = 3'b100
   } stage_t;
endpackage : fault_pkg

// >>> core/fault_table.sv
`timescale 1ns/10ps
`default_nettype none
// per-cause reaction lookup; index 0 is the lowest code
module fault_table
   import fault_pkg::*;
(
   input  wire logic [4:0]   idx,
   output fault_entry_t      entry
);
   function automatic fault_entry_t mk(input logic [7:0] c, input react_t r,
                                       input logic o, input int eb,
                                       input int xb);
      fault_entry_t e;
      e.code         = c;
      e.react        = r;
      e.contact_open = o;
      e.err_mask     = (eb < 0) ? 32'h0 : (32'h1 << eb);
      e.ext_mask     = (xb < 0) ? 32'h0 : (32'h1 << xb);
      return e;
   endfunction
   always_comb begin
      case (idx)
         5'h00: entry = mk(8'h09, REACT_COAST,   1'b0, 19, -1);
         5'h01: entry = mk(8'h10, REACT_INHIBIT, 1'b1, -1, -1);
         5'h02: entry = mk(8'h11, REACT_STOP,    1'b1, 23, -1);
         5'h03: entry = mk(8'h12, REACT_INHIBIT, 1'b0, 24, -1);
         5'h04: entry = mk(8'h13, REACT_INHIBIT, 1'b0, 12, -1);
         5'h05: entry = mk(8'h14, REACT_INHIBIT, 1'b0, -1, -1);
         5'h06: entry = mk(8'h15, REACT_STOP,    1'b0, 15, -1);
         5'h07: entry = mk(8'h16, REACT_COAST,   1'b1, 16, -1);
         5'h08: entry = mk(8'h17, REACT_STOP,    1'b0, 26, -1);
         5'h09: entry = mk(8'h18, REACT_STOP,    1'b0, 22, -1);
         5'h0a: entry = mk(8'h19, REACT_STOP,    1'b0, 2,  -1);
         5'h0b: entry = mk(8'h20, REACT_STOP,    1'b0, 20, -1);
         5'h0c: entry = mk(8'h25, REACT_STOP,    1'b0, 30, -1);
         5'h0d: entry = mk(8'h26, REACT_STOP,    1'b1, 31, -1);
         5'h0e: entry = mk(8'h27, REACT_INHIBIT, 1'b0, 27, -1);
         5'h0f: entry = mk(8'h28, REACT_STOP,    1'b0, -1, 19);
         5'h10: entry = mk(8'h29, REACT_STOP,    1'b0, 25, -1);
         5'h11: entry = mk(8'h30, REACT_INHIBIT, 1'b0, 17, -1);
         5'h12: entry = mk(8'h31, REACT_STOP,    1'b0, 15, -1);
         5'h13: entry = mk(8'h32, REACT_INHIBIT, 1'b0, 21, -1);
         default: entry = mk(8'h00, REACT_CONTROL, 1'b0, -1, -1);
      endcase
   end
endmodule // fault_table
`default_nettype wire

// >>> core/fault_reaction.sv
`timescale 1ns/10ps
`default_nettype none
`include "fault_consts.svh"
module fault_reaction
   import fault_pkg::*;
#(
   parameter int NF          = `N_FAULT,
   parameter int STOP_CYCLES = `STOP_CYCLES
)(
   input  wire logic          CLK_SYS,
   input  wire logic          ARST_N,
   input  wire logic [NF-1:0] FAULT_IN,
   input  wire logic          CYCLE_TICK,
   input  wire logic          CTRL_MSG_OK,
   input  wire logic          DC_SYNC_MODE,
   input  wire logic          DC_SYNC_BAD,
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [31:0]   PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic [31:0]        PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   output logic [7:0]         FAULT_CODE,
   output logic [31:0]        DRIVE_ERROR_WORD,
   output logic [31:0]        EXTENDED_STATUS_WORD,
   output logic               STAGE_ON,
   output logic               DECEL_REQ,
   output logic               EMERG_CONTACT_OPEN,
   output logic               DRIVE_READY,
   output logic               CLEAR_DONE
);
   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [NF-1:0] fin_s1_r;
   logic [NF-1:0] fin_s2_r;
   logic          msg_s1_r;
   logic          msg_s2_r;
   logic          bad_s1_r;
   logic          bad_s2_r;
   logic          tick_s1_r;
   logic          tick_s2_r;
   logic          tick_d_r;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         fin_s1_r  <= '0;
         fin_s2_r  <= '0;
         msg_s1_r  <= 1'b0;
         msg_s2_r  <= 1'b0;
         bad_s1_r  <= 1'b0;
         bad_s2_r  <= 1'b0;
         tick_s1_r <= 1'b0;
         tick_s2_r <= 1'b0;
         tick_d_r  <= 1'b0;
      end else begin
         fin_s1_r  <= FAULT_IN;
         fin_s2_r  <= fin_s1_r;
         msg_s1_r  <= CTRL_MSG_OK;
         msg_s2_r  <= msg_s1_r;
         bad_s1_r  <= DC_SYNC_BAD;
         bad_s2_r  <= bad_s1_r;
         tick_s1_r <= CYCLE_TICK;
         tick_s2_r <= tick_s1_r;
         tick_d_r  <= tick_s2_r;
      end
   end
   logic tick;
   assign tick = tick_s2_r & ~tick_d_r;

   ////////////////////////////////////////////////////////////////////////
   // consecutive-cycle counters for bus watchdog and sync
   logic [`CNT_W-1:0] miss_cnt_r;
   logic [`CNT_W-1:0] sync_cnt_r;
   logic              wd_fault;
   logic              sync_fault;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         miss_cnt_r <= '0;
      end else if (tick) begin
         if (msg_s2_r) begin
            miss_cnt_r <= '0;
         end else if (miss_cnt_r != `CNT_W'(`MISS_LIMIT)) begin
            miss_cnt_r <= miss_cnt_r + `CNT_W'(1);
         end
      end
   end
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_cnt_r <= '0;
      end else if (tick) begin
         if (!DC_SYNC_MODE || !bad_s2_r) begin
            sync_cnt_r <= '0;
         end else if (sync_cnt_r != `CNT_W'(`MISS_LIMIT)) begin
            sync_cnt_r <= sync_cnt_r + `CNT_W'(1);
         end
      end
   end
   assign wd_fault   = (miss_cnt_r == `CNT_W'(`MISS_LIMIT));
   assign sync_fault = (sync_cnt_r == `CNT_W'(`MISS_LIMIT));

   ////////////////////////////////////////////////////////////////////////
   // control register and clear edge
   logic [31:0] ctrl_r;
   logic        clr_d_r;
   logic        clear_pulse;
   logic        wr_acc;
   assign wr_acc = PSEL & PENABLE & PWRITE;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_r <= '0;
      end else if (wr_acc && PADDR == `REG_CTRL) begin
         ctrl_r <= PWDATA;
      end
   end
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         clr_d_r <= 1'b0;
      end else begin
         clr_d_r <= ctrl_r[`CTRL_CLEAR_BIT];
      end
   end
   // clear acts only on the rising edge and only with enable withdrawn
   assign clear_pulse = ctrl_r[`CTRL_CLEAR_BIT] & ~clr_d_r &
                        ~ctrl_r[`CTRL_ENABLE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // fault latches
   logic [NF-1:0] cause;
   logic [NF-1:0] latch_r;
   always_comb begin
      cause     = fin_s2_r;
      cause[`WD_IDX]   = fin_s2_r[`WD_IDX] | wd_fault;
      cause[`SYNC_IDX] = fin_s2_r[`SYNC_IDX] | sync_fault;
   end
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         latch_r <= '0;
      end else if (clear_pulse) begin
         latch_r <= cause;
      end else begin
         latch_r <= latch_r | cause;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-cause lookup and merge
   fault_entry_t  ent [NF];
   logic [31:0]   err_or [NF+1];
   logic [31:0]   ext_or [NF+1];
   logic          opn_or [NF+1];
   logic          cst_or [NF+1];
   logic          stp_or [NF+1];
   logic          inh_or [NF+1];
   assign err_or[0] = '0;
   assign ext_or[0] = '0;
   assign opn_or[0] = 1'b0;
   assign cst_or[0] = 1'b0;
   assign stp_or[0] = 1'b0;
   assign inh_or[0] = 1'b0;
   genvar g;
   generate
      for (g = 0; g < NF; g++) begin : g_ent
         fault_table u_tab (
            .idx   (5'(g)),
            .entry (ent[g])
         );
         assign err_or[g+1] = err_or[g] | (latch_r[g] ? ent[g].err_mask
                                                      : 32'h0);
         assign ext_or[g+1] = ext_or[g] | (latch_r[g] ? ent[g].ext_mask
                                                      : 32'h0);
         assign opn_or[g+1] = opn_or[g] | (latch_r[g] & ent[g].contact_open);
         assign cst_or[g+1] = cst_or[g] |
                              (latch_r[g] && ent[g].react == REACT_COAST);
         assign stp_or[g+1] = stp_or[g] |
                              (latch_r[g] && ent[g].react == REACT_STOP);
         assign inh_or[g+1] = inh_or[g] |
                              (latch_r[g] && ent[g].react == REACT_INHIBIT);
      end
   endgenerate
   logic [7:0] code_nxt;
   always_comb begin
      code_nxt = `CODE_NONE;
      for (int i = NF - 1; i >= 0; i--) begin
         if (latch_r[i]) begin
            code_nxt = ent[i].code;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output stage sequencing
   stage_t      stage_r;
   logic [31:0] stop_cnt_r;
   logic        any_fault;
   logic        en;
   assign any_fault = |latch_r;
   assign en        = ctrl_r[`CTRL_ENABLE_BIT];
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         stage_r    <= ST_OFF;
         stop_cnt_r <= '0;
      end else begin
         case (stage_r)
            ST_OFF: begin
               // inhibit or any latch keeps the stage off
               if (en && !any_fault) begin
                  stage_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (cst_or[NF] || !en) begin
                  stage_r <= ST_OFF;
               end else if (stp_or[NF] || inh_or[NF]) begin
                  stage_r    <= ST_STOP;
                  stop_cnt_r <= 32'(STOP_CYCLES);
               end
            end
            ST_STOP: begin
               if (cst_or[NF] || stop_cnt_r == 32'h0) begin
                  stage_r <= ST_OFF;
               end else begin
                  stop_cnt_r <= stop_cnt_r - 32'h1;
               end
            end
            default: stage_r <= ST_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         FAULT_CODE           <= `CODE_NONE;
         DRIVE_ERROR_WORD     <= '0;
         EXTENDED_STATUS_WORD <= '0;
         EMERG_CONTACT_OPEN   <= 1'b0;
         STAGE_ON             <= 1'b0;
         DECEL_REQ            <= 1'b0;
         DRIVE_READY          <= 1'b0;
         CLEAR_DONE           <= 1'b0;
      end else begin
         FAULT_CODE           <= code_nxt;
         DRIVE_ERROR_WORD     <= err_or[NF];
         EXTENDED_STATUS_WORD <= ext_or[NF];
         EMERG_CONTACT_OPEN   <= opn_or[NF];
         // coast drops the stage in the same cycle the code appears
         STAGE_ON             <= (stage_r != ST_OFF) && !cst_or[NF];
         DECEL_REQ            <= (stage_r == ST_STOP);
         DRIVE_READY          <= ~any_fault;
         CLEAR_DONE           <= clear_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read side
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA  <= '0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & ~PENABLE;
         PSLVERR <= 1'b0;
         PRDATA  <= '0;
         if (PSEL && !PENABLE) begin
            case (PADDR)
               `REG_CAUSE: PRDATA <= 32'(latch_r);
               `REG_ERRW:  PRDATA <= err_or[NF];
               `REG_EXTW:  PRDATA <= ext_or[NF];
               `REG_STAT:  PRDATA <= {21'h0, clear_pulse, ~any_fault,
                                      stage_r, code_nxt[5:0]} |
                                     (32'(CLEAR_DONE) << `CLEAR_ACK_BIT);
               `REG_CTRL:  PRDATA <= ctrl_r;
               default: begin
                  PSLVERR <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // fault_reaction
`default_nettype wire

// >>> dv/ctrl_msg_source.sv
`timescale 1ns/10ps
`default_nettype none
// far-side controller: one control cycle every 8 clocks, message per cycle
module ctrl_msg_source (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic drop,
   output logic      tick,
   output logic      msg_ok
);
   logic [2:0] ph_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_r   <= 3'h0;
         msg_ok <= 1'b0;
      end else begin
         ph_r   <= ph_r + 3'h1;
         msg_ok <= !drop;
      end
   end
   assign tick = ph_r[2];
endmodule // ctrl_msg_source
`default_nettype wire

// >>> dv/fault_reaction_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "fault_consts.svh"
module fault_reaction_chk #(
   parameter int NF = 20
)(
   input wire logic          CLK_SYS,
   input wire logic          ARST_N,
   input wire logic [NF-1:0] FAULT_IN,
   input wire logic          PSEL,
   input wire logic          PENABLE,
   input wire logic          PWRITE,
   input wire logic [31:0]   PADDR,
   input wire logic          PREADY,
   input wire logic          PSLVERR,
   input wire logic [7:0]    FAULT_CODE,
   input wire logic [31:0]   DRIVE_ERROR_WORD,
   input wire logic          STAGE_ON,
   input wire logic          EMERG_CONTACT_OPEN,
   input wire logic          DRIVE_READY,
   input wire logic          CLEAR_DONE
);
   // cycles since the last control write, saturating
   logic [2:0] wcnt_r;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) wcnt_r <= 3'h7;
      else if (PSEL && PENABLE && PWRITE && PADDR == `REG_CTRL) wcnt_r <= 3'h0;
      else if (wcnt_r != 3'h7) wcnt_r <= wcnt_r + 3'h1;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   a_pready_next: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready in first access cycle");
   a_unmapped_err: assert property (PSEL && !PENABLE && PADDR > `REG_CTRL
      |=> PSLVERR && PREADY) else $error("unmapped access not refused");
   a_first_code: assert property ($rose(FAULT_IN[0]) |->
      ##[3:5] FAULT_CODE == 8'h09) else $error("code 09 not shown");
   a_idle_state: assert property (DRIVE_READY |-> FAULT_CODE == 8'h00 &&
      DRIVE_ERROR_WORD == 32'h0 && !EMERG_CONTACT_OPEN)
      else $error("ready with fault shown");
   a_contact_rel: assert property (FAULT_CODE inside {8'h10, 8'h11, 8'h16,
      8'h26} |-> EMERG_CONTACT_OPEN) else $error("contact not released");
   a_coast_off: assert property (FAULT_CODE inside {8'h09, 8'h16}
      |-> !STAGE_ON) else $error("stage on while coasting");
   a_latch_hold: assert property ($fell(|DRIVE_ERROR_WORD)
      |-> wcnt_r < 3'h6) else $error("error word dropped without clear");
   a_clear_pulse: assert property (CLEAR_DONE |=> !CLEAR_DONE)
      else $error("clear flag longer than one cycle");
   a_wdog_bit: assert property (FAULT_CODE == 8'h15
      |-> DRIVE_ERROR_WORD[15]) else $error("bit 15 missing");
   c_clear: cover property (CLEAR_DONE);
   c_open: cover property (EMERG_CONTACT_OPEN);
   c_refuse: cover property (PSLVERR && PREADY);
endmodule // fault_reaction_chk
bind fault_reaction fault_reaction_chk #(.NF(NF)) u_chk (.CLK_SYS, .ARST_N,
   .FAULT_IN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY, .PSLVERR,
   .FAULT_CODE, .DRIVE_ERROR_WORD, .STAGE_ON, .EMERG_CONTACT_OPEN,
   .DRIVE_READY, .CLEAR_DONE);
`default_nettype wire

// >>> dv/servo_fault_reaction_encoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "fault_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module servo_fault_reaction_encoder_tb;
   localparam logic [7:0] CD [20] = '{8'h09, 8'h10, 8'h11, 8'h12, 8'h13,
      8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h20, 8'h25, 8'h26, 8'h27,
      8'h28, 8'h29, 8'h30, 8'h31, 8'h32};
   localparam int EB [20] = '{19, -1, 23, 24, 12, -1, 15, 16, 26, 22, 2, 20,
      30, 31, 27, -1, 25, 17, 15, 21};
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [19:0] fin = 20'h0;
   logic        smode = 1'b0, sbad = 1'b0, drop = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, ew, prdata, errw, extw;
   logic        serr, cdn, pready, pslverr, son, decel, copen, rdy, done;
   logic [7:0]  code;
   wire logic   tick, msg_ok;
   int          miscompares = 0, checks = 0, i;
   fault_reaction #(.STOP_CYCLES(10)) u_dut (.CLK_SYS(clk), .ARST_N(arst_n),
      .FAULT_IN(fin), .CYCLE_TICK(tick), .CTRL_MSG_OK(msg_ok),
      .DC_SYNC_MODE(smode), .DC_SYNC_BAD(sbad), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .FAULT_CODE(code),
      .DRIVE_ERROR_WORD(errw), .EXTENDED_STATUS_WORD(extw), .STAGE_ON(son),
      .DECEL_REQ(decel), .EMERG_CONTACT_OPEN(copen), .DRIVE_READY(rdy),
      .CLEAR_DONE(done));
   ctrl_msg_source u_src (.clk(clk), .arst_n(arst_n), .drop(drop),
      .tick(tick), .msg_ok(msg_ok));
   initial forever #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (!pready);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic clr;
      fin <= 20'h0;
      apb(1'b1, `REG_CTRL, 32'h0);
      apb(1'b1, `REG_CTRL, 32'h200);
      cdn = 1'b0;
      repeat (6) begin
         @(posedge clk);
         cdn |= done;
      end
      apb(1'b1, `REG_CTRL, 32'h0);
      repeat (3) @(posedge clk);
   endtask
   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("code", 8'h00, code)
      `CHK("ready", 1'b1, rdy)
      `CHK("open", 1'b0, copen)
      $display("test reset done");
      for (i = 0; i < 20; i++) begin
         fin <= 20'h1 << i;
         repeat (6) @(posedge clk);
         ew = (EB[i] < 0) ? 32'h0 : 32'h1 << EB[i];
         `CHK("code", CD[i], code) // to
         `CHK("errw", ew, errw) // to
         `CHK("extw", (i == 15) ? 32'h0008_0000 : 32'h0, extw)
         `CHK("open", i inside {1, 2, 7, 13}, copen)
         fin <= 20'h0;
         repeat (6) @(posedge clk);
         `CHK("held", CD[i], code)
         `CHK("ready", 1'b0, rdy)
         clr;
         `CHK("cleared", 1'b1, cdn)
         `CHK("code", 8'h00, code)
         $display("test row %0d done", i);
      end
      fin <= 20'h8_0008;
      repeat (6) @(posedge clk);
      apb(1'b0, `REG_ERRW, 32'h0);
      `CHK("code", 8'h12, code)
      `CHK("errw", 32'h0120_0000, rd)
      clr;
      $display("test multi done");
      apb(1'b1, `REG_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      `CHK("stage", 1'b1, son)
      fin <= 20'h4;
      repeat (6) @(posedge clk);
      `CHK("decel", 1'b1, decel)
      `CHK("stage", 1'b1, son)
      repeat (14) @(posedge clk);
      `CHK("stopped", 1'b0, son)
      apb(1'b1, `REG_CTRL, 32'h201);
      repeat (4) @(posedge clk);
      `CHK("noclear", 8'h11, code)
      clr;
      `CHK("code", 8'h00, code)
      $display("test stage done");
      @(posedge tick);
      drop <= 1'b1;
      repeat (2) @(posedge tick);
      drop <= 1'b0;
      repeat (3) @(posedge tick);
      `CHK("code", 8'h00, code)
      drop <= 1'b1;
      repeat (4) @(posedge tick);
      repeat (6) @(posedge clk);
      `CHK("code", 8'h15, code)
      `CHK("errw", 32'h0000_8000, errw)
      drop <= 1'b0;
      clr;
      $display("test watchdog done");
      smode <= 1'b1;
      sbad <= 1'b1;
      repeat (4) @(posedge tick);
      repeat (6) @(posedge clk);
      `CHK("code", 8'h31, code)
      `CHK("errw", 32'h0000_8000, errw)
      sbad <= 1'b0;
      clr;
      $display("test sync done");
      apb(1'b0, 32'h0000_0020, 32'h0);
      `CHK("slverr", 1'b1, serr)
      $display("test unmapped done");
      conclude;
   end
   initial begin
      #100000;
      miscompares++;
      conclude;
   end
endmodule // servo_fault_reaction_encoder_tb
`default_nettype wire
